// file: disk_command_core.sv
// Disk controller command core: command/status port, 1 KB buffer, disk
// sequencer and byte clock counter.
// Assumes host strobes and drive inputs synchronous to clock; the drive
// gives one bit_tick per bit cell.
`timescale 1ns/100ps
`include "disk_core_map.svh"
module disk_command_core
  import disk_core_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       host_addr,
  input  wire logic [7:0] host_wdata,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  output logic      [7:0] host_rdata,
  output logic            host_irq,
  input  drive_in_t       drive_in,
  output drive_out_t      drive_out,
  output bus_view_t       bus_view
);

  typedef struct packed {
    fsm_t              fsm;
    logic [7:0]        cmd;
    logic [7:0]        status;
    logic              cleared;
    logic              irq;
    logic              irq_en;
    logic [9:0]        ptr;
    logic [7:0]        rdata;
    logic [7:0]        rd_latch;
    logic [7:0]        fault_bits;
    logic              retried;
    logic [7:0]        sector_cnt;
    logic [2:0]        bit_cnt;
    logic              synced;
    logic [7:0]        shift;
    logic [9:0]        byte_idx;
    logic [9:0]        dma_addr;
    drive_out_t        dout;
    bus_view_t         view;
    logic [1023:0][7:0] mem;
  } core_t;

  core_t      cur;
  core_t      next_cur;
  logic [2:0] op;
  logic       is_write_op;
  logic       byte_end;
  logic [7:0] sector_next;

  assign op          = cur.cmd[3:1];
  assign is_write_op = (op == `OP_WRITE);
  assign byte_end    = drive_in.bit_tick && (cur.bit_cnt == `BIT_LAST);
  assign sector_next = drive_in.index_pulse ? 8'h00 :
                       8'(cur.sector_cnt + 8'h01);

  always_comb begin
    next_cur = cur;
    next_cur.rdata = 8'h00;
    next_cur.dout.seek_strobe = 1'b0;
    next_cur.dout.restore = 1'b0;
    next_cur.dout.check_reset = 1'b0;
    next_cur.view.io_space_select = 1'b0;
    next_cur.view.buffer_write_sel = 1'b1;
    next_cur.view.buffer_ram_enable = 1'b0;
    next_cur.view.disk_op_launch = 1'b0;
    next_cur.view.dma_cycle_enable = 1'b0;
    next_cur.view.command_latch_strobe = 1'b0;
    next_cur.view.sector_count_clear = 1'b0;
    next_cur.view.counter_preset = 1'b0;
    next_cur.view.dma_done = 1'b0;

    // Command/status port seen by the processor in its I/O space
    if ((host_wr || host_rd) && host_addr == `PORT_CMD_STATUS) begin
      next_cur.view.io_space_select = 1'b1;
    end
    if (host_rd && host_addr == `PORT_CMD_STATUS) begin
      next_cur.rdata = cur.status;
    end

    // Data port: buffer access when the disk side does not own the bus
    if (!cur.view.dma_access_grant) begin
      if (host_wr && host_addr == `PORT_DATA) begin
        next_cur.mem[cur.ptr] = host_wdata;
        next_cur.ptr = 10'(cur.ptr + 10'h001);
        next_cur.view.buffer_ram_enable = 1'b1;
        next_cur.view.buffer_write_sel = 1'b0;
      end
      if (host_rd && host_addr == `PORT_DATA) begin
        // Answer is the fault bits under a fault status, else the byte fetched on the previous read
        next_cur.rdata = (cur.status[6:0] == `ERR_FAULT) ?
                         cur.fault_bits : cur.rd_latch;
        next_cur.rd_latch = cur.mem[cur.ptr];
        next_cur.ptr = 10'(cur.ptr + 10'h001);
        next_cur.view.buffer_ram_enable = 1'b1;
        next_cur.view.buffer_write_sel = 1'b1;
      end
    end
    else if (host_rd && host_addr == `PORT_DATA) begin
      next_cur.rdata = cur.rd_latch;
    end

    // Zero command ends the handshake of a running command
    if (host_wr && host_addr == `PORT_CMD_STATUS && host_wdata == 8'h00 &&
        cur.fsm != S_IDLE) begin
      next_cur.cleared = 1'b1;
    end

    // Byte clock counter, counting bit cells while a sector is transferred
    if (cur.fsm == S_XFER || cur.fsm == S_CRC) begin
      if (drive_in.bit_tick) begin
        next_cur.bit_cnt = 3'(cur.bit_cnt + 3'h1);
      end
    end
    next_cur.dout.byte_strobe = (next_cur.bit_cnt == `BIT_LAST) &&
        (next_cur.fsm == S_XFER || next_cur.fsm == S_CRC);

    unique case (cur.fsm)
      S_IDLE: begin
        if (host_wr && host_addr == `PORT_CMD_STATUS &&
            host_wdata != 8'h00) begin
          next_cur.view.command_latch_strobe = 1'b1;
          next_cur.cmd = host_wdata;
          next_cur.status = 8'h80;
          next_cur.cleared = 1'b0;
          next_cur.irq_en = host_wdata[`CMD_IRQ_BIT];
          if (host_wdata[`CMD_DISK_BIT]) begin
            next_cur.retried = 1'b0;
            next_cur.view.disk_op_launch = 1'b1;
            next_cur.view.cpu_bus_request = 1'b1;
            next_cur.fsm = S_GRANT;
          end
          else begin
            if (host_wdata[`CMD_IRQ_CLR_BIT]) begin
              next_cur.irq = 1'b0;
            end
            unique case (host_wdata[5:4])
              2'h0: next_cur.ptr = 10'h000;
              2'h1: next_cur.ptr = `BUF_DATA;
              2'h2: next_cur.ptr = `BUF_USER_PTR_LO;
              2'h3: next_cur.ptr = {cur.mem[`BUF_USER_PTR_HI][1:0],
                                    cur.mem[`BUF_USER_PTR_LO]};
            endcase
            next_cur.status[6:0] = `ERR_NONE;
            next_cur.fsm = S_DONE;
          end
        end
      end
      S_GRANT: begin
        // Processor has floated its buses; DMA may take them now
        next_cur.view.dma_access_grant = 1'b1;
        next_cur.dout.unit_sel = cur.mem[`BUF_UNIT][1:0];
        next_cur.dout.head = cur.mem[`BUF_HEAD];
        next_cur.dout.cylinder = {cur.mem[`BUF_CYL_HI],
                                  cur.mem[`BUF_CYL_LO]};
        next_cur.fault_bits = 8'h00;
        next_cur.fsm = S_CHECK;
      end
      S_CHECK: begin
        if (!drive_in.ready) begin
          next_cur.status[6:0] = `ERR_NOT_READY;
          next_cur.fsm = S_FINISH;
        end
        else if (drive_in.fault) begin
          if (!cur.retried) begin
            next_cur.retried = 1'b1;
            next_cur.dout.restore = 1'b1;
            next_cur.fsm = S_RESTORE;
          end
          else begin
            next_cur.fault_bits[`FAULT_FL_BIT] = 1'b1;
            next_cur.status[6:0] = `ERR_FAULT;
            next_cur.fsm = S_FINISH;
          end
        end
        else if ((is_write_op || op == `OP_WRITE_CHECK) &&
                 drive_in.write_protect) begin
          next_cur.status[6:0] = `ERR_WRITE_PROT;
          next_cur.fsm = S_FINISH;
        end
        else if (op == `OP_WRITE_CHECK) begin
          next_cur.status[6:0] = `ERR_NONE;
          next_cur.fsm = S_FINISH;
        end
        else if (op == `OP_RESTORE) begin
          if (cur.retried) begin
            next_cur.status[6:0] = `ERR_NONE;
            next_cur.fsm = S_FINISH;
          end
          else begin
            next_cur.retried = 1'b1;
            next_cur.dout.restore = 1'b1;
            next_cur.fsm = S_RESTORE;
          end
        end
        else if (op == `OP_READ_CHECK && !cur.cmd[`CMD_SEEK_BIT]) begin
          next_cur.status[6:0] = `ERR_NONE;
          next_cur.fsm = S_FINISH;
        end
        else begin
          next_cur.dout.seek_strobe = 1'b1;
          next_cur.fsm = S_SEEK;
        end
      end
      S_RESTORE: begin
        // Head back at track zero, then look at the drive once more
        if (!cur.dout.restore && drive_in.on_cylinder) begin
          next_cur.bit_cnt = 3'h0;
          next_cur.fsm = S_CHECK;
        end
      end
      S_SEEK: begin
        if (!cur.dout.seek_strobe && drive_in.on_cylinder) begin
          if (drive_in.seek_error) begin
            next_cur.fault_bits[`FAULT_SE_BIT] = 1'b1;
            next_cur.status[6:0] = `ERR_FAULT;
            next_cur.fsm = S_FINISH;
          end
          else if (op == `OP_READ_CHECK) begin
            next_cur.status[6:0] = `ERR_NONE;
            next_cur.fsm = S_FINISH;
          end
          else begin
            next_cur.fsm = S_SECTOR;
          end
        end
      end
      S_SECTOR: begin
        if (drive_in.index_pulse || drive_in.sector_pulse) begin
          next_cur.sector_cnt = sector_next;
          next_cur.view.sector_count_clear = 1'b1;
          next_cur.bit_cnt = 3'h0;
          if (sector_next == cur.mem[`BUF_SECTOR]) begin
            next_cur.dout.check_reset = 1'b1;
            next_cur.dma_addr = `BUF_DATA;
            next_cur.byte_idx = 10'h000;
            next_cur.synced = 1'b0;
            if (is_write_op) begin
              next_cur.shift = cur.mem[`BUF_DATA];
              next_cur.dma_addr = 10'(`BUF_DATA + 10'h001);
            end
            else begin
              next_cur.bit_cnt = `BIT_PRESET;
              next_cur.view.counter_preset = 1'b1;
            end
            next_cur.fsm = S_XFER;
          end
        end
      end
      S_XFER: begin
        if (drive_in.bit_tick) begin
          next_cur.shift = {cur.shift[6:0], drive_in.read_bit};
        end
        if (byte_end) begin
          next_cur.view.dma_cycle_enable = 1'b1;
          next_cur.view.buffer_ram_enable = 1'b1;
          if (is_write_op) begin
            // Load on byte end, shift on the other bit cells; the load wins over the byte-end shift
            next_cur.shift = cur.mem[cur.dma_addr];
            next_cur.dma_addr = 10'(cur.dma_addr + 10'h001);
            next_cur.view.buffer_write_sel = 1'b1;
          end
          else if (cur.synced) begin
            next_cur.mem[cur.dma_addr] = {cur.shift[6:0],
                                          drive_in.read_bit};
            next_cur.dma_addr = 10'(cur.dma_addr + 10'h001);
            next_cur.view.buffer_write_sel = 1'b0;
          end
          else begin
            // First strobe after the preset only aligns the byte
            next_cur.synced = 1'b1;
            next_cur.view.buffer_ram_enable = 1'b0;
          end
          if (is_write_op || cur.synced) begin
            next_cur.byte_idx = 10'(cur.byte_idx + 10'h001);
            if (cur.byte_idx == `DATA_LAST_BYTE) begin
              next_cur.view.dma_done = 1'b1;
              next_cur.byte_idx = 10'h000;
              next_cur.fsm = S_CRC;
            end
          end
        end
      end
      S_CRC: begin
        if (drive_in.bit_tick) begin
          next_cur.shift = {cur.shift[6:0], 1'b0};
        end
        if (byte_end) begin
          next_cur.byte_idx = 10'(cur.byte_idx + 10'h001);
          if (cur.byte_idx == `CHECK_LAST_BYTE) begin
            next_cur.status[6:0] = `ERR_NONE;
            next_cur.fsm = S_FINISH;
          end
        end
      end
      S_FINISH: begin
        next_cur.view.cpu_bus_request = 1'b0;
        next_cur.view.dma_access_grant = 1'b0;
        next_cur.fsm = S_DONE;
      end
      S_DONE: begin
        if (cur.cleared) begin
          next_cur.status[`STATUS_BUSY_BIT] = 1'b0;
          next_cur.cleared = 1'b0;
          if (cur.irq_en) begin
            next_cur.irq = 1'b1;
          end
          next_cur.fsm = S_IDLE;
        end
      end
    endcase

    // Gates and serial data follow the state being entered
    next_cur.dout.read_transfer_gate = (next_cur.fsm == S_XFER) ||
                                       (next_cur.fsm == S_CRC);
    next_cur.dout.write_gate = next_cur.dout.read_transfer_gate &&
                               is_write_op;
    next_cur.dout.write_bit = next_cur.dout.write_gate &&
                              next_cur.shift[7];
    next_cur.dout.check_word_enable = (next_cur.fsm == S_CRC) &&
                                      is_write_op;
    next_cur.dout.byte_window = (next_cur.bit_cnt[2:1] == 2'h3) &&
                                next_cur.dout.read_transfer_gate;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.fsm <= S_IDLE;
      cur.view.buffer_write_sel <= 1'b1;
    end
    else begin
      cur <= next_cur;
    end
  end

  assign host_rdata = cur.rdata;
  assign host_irq   = cur.irq;
  assign drive_out  = cur.dout;
  assign bus_view   = cur.view;

endmodule

// file: disk_core_map.svh
// Offsets, field positions, codes and counts of the disk command core.
// Assumes inclusion by the core only.
`ifndef DISK_CORE_MAP_SVH
`define DISK_CORE_MAP_SVH
`define PORT_CMD_STATUS   1'b0
`define PORT_DATA         1'b1
`define CMD_IRQ_BIT       7
`define CMD_IRQ_CLR_BIT   6
`define CMD_SEEK_BIT      4
`define CMD_DISK_BIT      0
`define STATUS_BUSY_BIT   7
`define OP_RESTORE        3'h1
`define OP_READ           3'h2
`define OP_READ_CHECK     3'h3
`define OP_WRITE          3'h4
`define OP_WRITE_CHECK    3'h5
`define ERR_NONE          7'h00
`define ERR_NOT_READY     7'h05
`define ERR_WRITE_PROT    7'h0b
`define ERR_FAULT         7'h0f
`define BUF_UNIT          10'h001
`define BUF_SECTOR        10'h002
`define BUF_HEAD          10'h003
`define BUF_CYL_LO        10'h004
`define BUF_CYL_HI        10'h005
`define BUF_DATA          10'h008
`define BUF_USER_PTR_LO   10'h3fe
`define BUF_USER_PTR_HI   10'h3ff
`define DATA_LAST_BYTE    10'h1ff
`define CHECK_LAST_BYTE   10'h001
`define BIT_LAST          3'h7
`define BIT_PRESET        3'h6
`define IO_SPACE_TOP      2'h3
`define FAULT_FL_BIT      0
`define FAULT_SE_BIT      1
`endif

// file: disk_core_pkg.sv
// Types shared by the disk command core and its surroundings.
// Assumes the constants header is on the include path.
package disk_core_pkg;
  typedef enum logic [9:0] {
    S_IDLE    = 10'h001,
    S_GRANT   = 10'h002,
    S_CHECK   = 10'h004,
    S_RESTORE = 10'h008,
    S_SEEK    = 10'h010,
    S_SECTOR  = 10'h020,
    S_XFER    = 10'h040,
    S_CRC     = 10'h080,
    S_FINISH  = 10'h100,
    S_DONE    = 10'h200
  } fsm_t;
  typedef struct packed {
    logic ready;
    logic fault;
    logic write_protect;
    logic seek_error;
    logic on_cylinder;
    logic index_pulse;
    logic sector_pulse;
    logic bit_tick;
    logic read_bit;
  } drive_in_t;
  typedef struct packed {
    logic [1:0] unit_sel;
    logic [7:0] head;
    logic [15:0] cylinder;
    logic seek_strobe;
    logic restore;
    logic read_transfer_gate;
    logic write_gate;
    logic write_bit;
    logic byte_strobe;
    logic byte_window;
    logic check_word_enable;
    logic check_reset;
  } drive_out_t;
  typedef struct packed {
    logic io_space_select;
    logic buffer_write_sel;
    logic buffer_ram_enable;
    logic cpu_bus_request;
    logic dma_access_grant;
    logic disk_op_launch;
    logic dma_cycle_enable;
    logic command_latch_strobe;
    logic sector_count_clear;
    logic counter_preset;
    logic dma_done;
  } bus_view_t;
endpackage

// file: disk_core_properties.sv
// Port checks of the disk command core.
// Assumes one clock with asynchronous active-high reset.
`timescale 1ns/100ps
module disk_core_properties
  import disk_core_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       host_addr,
  input  wire logic [7:0] host_wdata,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic [7:0] host_rdata,
  input  wire logic       host_irq,
  input  drive_in_t       drive_in,
  input  drive_out_t      drive_out,
  input  bus_view_t       bus_view
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_strobe_in_window: assert property (drive_out.byte_strobe |->
    drive_out.byte_window) else $error("strobe outside window");
  a_window_leads: assert property ($rose(drive_out.byte_window) |->
    !drive_out.byte_strobe) else $error("window starts late");
  a_preset_six: assert property (bus_view.counter_preset |-> ##[0:2]
    (drive_out.byte_window && !drive_out.byte_strobe)) else $error("no preset");
  a_gate_pair: assert property (drive_out.write_gate |->
    drive_out.read_transfer_gate) else $error("write gate alone");
  a_hand_over: assert property (bus_view.disk_op_launch |->
    bus_view.cpu_bus_request ##1 bus_view.dma_access_grant)
    else $error("no grant after launch");
  a_dma_in_grant: assert property (bus_view.dma_cycle_enable |->
    bus_view.dma_access_grant) else $error("dma cycle without grant");
  a_done_in_grant: assert property (bus_view.dma_done |->
    bus_view.dma_access_grant) else $error("done without grant");
  a_latch_cause: assert property (bus_view.command_latch_strobe |->
    $past(host_wr && !host_addr && host_wdata != 8'h00))
    else $error("latch without command");
  a_launch_disk: assert property (bus_view.disk_op_launch |->
    bus_view.command_latch_strobe && $past(host_wdata[0]))
    else $error("launch without disk command");
  a_io_select: assert property (bus_view.io_space_select |->
    $past((host_wr || host_rd) && !host_addr)) else $error("stray io select");
  a_dir_access: assert property (!bus_view.buffer_write_sel |->
    bus_view.buffer_ram_enable) else $error("write select while idle");
  a_irq_clear: assert property ($fell(host_irq) |->
    $past(host_wr && host_wdata[6]) || $past(host_wr && host_wdata[6], 2))
    else $error("irq dropped without clear");
  c_done: cover property (bus_view.dma_done);
  c_preset: cover property (bus_view.counter_preset);
  c_irq_clear: cover property ($fell(host_irq));
  c_fault_restore: cover property (drive_in.fault && drive_out.restore);
endmodule
bind disk_command_core disk_core_properties i_props (
  .clock(clock), .rst(rst), .host_addr(host_addr), .host_wdata(host_wdata),
  .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
  .host_irq(host_irq), .drive_in(drive_in), .drive_out(drive_out),
  .bus_view(bus_view));

// file: drive_model.sv
// Drive model: bit cells, index and sector pulses, seek settling.
// Assumes the bench sets the ready, fault and protect levels.
`timescale 1ns/100ps
module drive_model
  import disk_core_pkg::*;
#(
  parameter int SECT_BITS = 4400
)(
  input  wire logic clock,
  input  wire logic rst,
  input  drive_out_t drive_out,
  input  wire logic ready_en,
  input  wire logic fault_en,
  input  wire logic protect_en,
  output drive_in_t drive_in
);
  int   bit_n;
  int   settle;
  logic phase;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      drive_in <= '0;
      bit_n    <= 0;
      settle   <= 0;
      phase    <= 1'b0;
    end else begin
      phase                  <= ~phase;
      drive_in.bit_tick      <= phase;
      drive_in.index_pulse   <= phase && bit_n == 0;
      drive_in.sector_pulse  <= phase && bit_n == SECT_BITS;
      if (phase)
        bit_n <= (bit_n == 2 * SECT_BITS - 1) ? 0 : bit_n + 1;
      // Ones under the gate, a changing pattern elsewhere
      drive_in.read_bit      <= drive_out.read_transfer_gate | bit_n[0];
      drive_in.ready         <= ready_en;
      drive_in.fault         <= fault_en;
      drive_in.write_protect <= protect_en;
      drive_in.seek_error    <= 1'b0;
      if (drive_out.seek_strobe || drive_out.restore) begin
        settle               <= 20;
        drive_in.on_cylinder <= 1'b0;
      end else if (settle > 1)
        settle <= settle - 1;
      else
        drive_in.on_cylinder <= 1'b1;
    end
  end
endmodule

// file: disk_controller_command_core_tb_top.sv
// Bench top: host port driver, drive model and buffer model.
// Assumes the core, its package and the drive model are compiled first.
`timescale 1ns/100ps
module disk_controller_command_core_tb_top;
  import disk_core_pkg::*;
  logic        clock      = 1'b0;
  logic        rst        = 1'b1;
  logic        host_addr  = 1'b0;
  logic [7:0]  host_wdata = 8'h00;
  logic        host_wr    = 1'b0;
  logic        host_rd    = 1'b0;
  logic        ready_en   = 1'b1;
  logic        fault_en   = 1'b0;
  logic        protect_en = 1'b0;
  logic [7:0]  host_rdata;
  logic        host_irq;
  drive_in_t   drive_in;
  drive_out_t  drive_out;
  bus_view_t   bus_view;
  int          bad_count  = 0;
  int          n_tests    = 0;
  int          restores   = 0;
  int          seeks      = 0;
  int          gates      = 0;
  int          dones      = 0;
  int          mem [520];
  int          wbits      = 0;
  logic [7:0]  wbyte      = 8'h00;
  logic [7:0]  wq [$];
  // Command, drive levels, status, restores, seeks (f: not checked)
  logic [31:0] cases [6] = '{32'h03_4_00_1_f_0, 32'h0b_5_0b_0_f_0,
    32'h0b_4_00_0_f_0, 32'h17_4_00_0_1_0, 32'h07_6_0f_1_f_0,
    32'h07_0_05_0_f_0};
  always #10 clock = ~clock;
  always @(posedge clock) begin
    restores <= restores + drive_out.restore;
    seeks    <= seeks + drive_out.seek_strobe;
    gates    <= gates + drive_out.read_transfer_gate;
    dones    <= dones + bus_view.dma_done;
  end
  // Serial write data as the drive takes it, one bit per cell
  always @(posedge clock) begin
    if (drive_out.write_gate && drive_in.bit_tick &&
        !drive_out.check_word_enable) begin
      wbyte <= {wbyte[6:0], drive_out.write_bit};
      wbits <= wbits + 1;
      if (wbits[2:0] == 3'h7)
        wq.push_back({wbyte[6:0], drive_out.write_bit});
    end
  end
  disk_command_core i_dut (
    .clock(clock), .rst(rst), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata), .host_irq(host_irq), .drive_in(drive_in),
    .drive_out(drive_out), .bus_view(bus_view));
  drive_model i_drive (
    .clock(clock), .rst(rst), .drive_out(drive_out), .ready_en(ready_en),
    .fault_en(fault_en), .protect_en(protect_en), .drive_in(drive_in));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge clock);
    host_addr  <= a;
    host_wdata <= d;
    host_wr    <= 1'b1;
    @(posedge clock);
    host_wr <= 1'b0;
  endtask
  task automatic rd(input logic a, output logic [7:0] d);
    @(posedge clock);
    host_addr <= a;
    host_rd   <= 1'b1;
    @(posedge clock);
    host_rd <= 1'b0;
    @(negedge clock);
    d = host_rdata;
  endtask
  task automatic cmd(input logic [7:0] c, output logic [7:0] st);
    int i;
    wr(1'b0, c);
    st = 8'h00;
    for (i = 0; i < 50 && st[7] === 1'b0; i++)
      rd(1'b0, st);
    check(st[7], 1'b1, "command taken");
    wr(1'b0, 8'h00);
    for (i = 0; i < 20000 && st[7] !== 1'b0; i++)
      rd(1'b0, st);
    check(st[7], 1'b0, "command done");
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize;
  end
  initial begin
    logic [7:0] d;
    logic [7:0] st;
    int i, k, head, cyl, unit, r0, s0, g0, d0;
    void'($urandom(97540));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check(bus_view, 16'h0200, "idle bus view");
    rd(1'b0, st);
    check(st, 8'h00, "status after reset");
    cmd(8'h06, st);
    unit = $urandom % 4;
    head = $urandom % 6;
    cyl  = $urandom % 808;
    for (i = 0; i < 520; i++)
      mem[i] = (i < 6) ? 0 : $urandom % 256;
    mem[0] = 8;
    mem[1] = unit;
    mem[2] = 1;
    mem[3] = head;
    mem[4] = cyl % 256;
    mem[5] = cyl / 256;
    mem[6] = 0;
    mem[7] = 0;
    for (i = 0; i < 520; i++)
      wr(1'b1, mem[i][7:0]);
    cmd(8'h12, st);
    rd(1'b1, d);
    for (i = 8; i < 24; i++) begin
      rd(1'b1, d);
      check(d, mem[i][7:0], "buffer byte");
    end
    g0 = gates;
    d0 = dones;
    cmd(8'h19, st);
    check(st, 8'h00, "write status");
    check(gates > g0, 1'b1, "gate in write");
    check(dones - d0, 1, "done in write");
    check(wq.size(), 512, "bytes written");
    for (i = 0; i < 512 && i < wq.size(); i++)
      check(wq[i], mem[i + 8][7:0], "written byte");
    check(drive_out.head, head[7:0], "head");
    check(drive_out.cylinder, cyl[15:0], "cylinder");
    check(drive_out.unit_sel, unit[1:0], "unit");
    cmd(8'h95, st);
    check(st, 8'h00, "read status");
    check(host_irq, 1'b1, "irq raised");
    for (i = 8; i < 520; i++)
      mem[i] = 255;
    cmd(8'h92, st);
    rd(1'b1, d);
    for (i = 8; i < 520; i++) begin
      rd(1'b1, d);
      check(d, mem[i][7:0], "disk byte");
    end
    cmd(8'h40, st);
    check(host_irq, 1'b0, "irq cleared");
    for (k = 0; k < 6; k++) begin
      @(posedge clock);
      {ready_en, fault_en, protect_en} <= cases[k][22:20];
      repeat (2) @(posedge clock);
      r0 = restores;
      s0 = seeks;
      g0 = gates;
      cmd(cases[k][31:24], st);
      check(st, cases[k][19:12], "op status");
      check(restores - r0, cases[k][11:8], "restores");
      check(gates - g0, 0, "no transfer");
      if (cases[k][7:4] != 4'hf)
        check(seeks - s0, cases[k][7:4], "seeks");
      if (st == 8'h0f) begin
        rd(1'b1, d);
        rd(1'b1, d);
        check(d[0], 1'b1, "fault bit");
      end
    end
    summarize;
  end
endmodule
